/* File: verilog/mcs_cfg.svh */
/*
 * Constants of the converter stream port: flag bit positions, reset
 * values and default pacing and packet figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH

// Positions of the three sticky event flags in the flag vector.
`define MCS_FLAG_MISS 0
`define MCS_FLAG_PERR 1
`define MCS_FLAG_LOST 2
`define MCS_FLAG_N 3

// Reset values of the flag vector and of the mixer phase.
`define MCS_FLAGS_RST 3'h0
`define MCS_PHASE_RST 2'h0

// Default width of one aggregate input word, I in the upper half.
`define MCS_SAMPLE_W 32

// Default samples per input packet and clocks per input sample slot.
`define MCS_PKT_LEN 4
`define MCS_IN_PERIOD 8

`endif

/* File: verilog/mcs_pkg.sv */
/*
 * Types shared by the converter stream port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mcs_pkg;

   // Input pacing: waiting for the first sample, idle between slots,
   // or offering a slot with input_ready high.
   typedef enum logic [1:0] {
      MCS_IN_FIRST,
      MCS_IN_WAIT,
      MCS_IN_SLOT
   } mcs_in_state_t;

   // Packet engine: idle, or reading a stored packet back.
   typedef enum logic {
      MCS_EN_IDLE,
      MCS_EN_READ
   } mcs_en_state_t;

endpackage

/* File: verilog/mcs_sample_mem.sv */
/*
 * Small two-bank sample store with a registered read port.
 * Assumes one clock; contents are never reset so that a reset of the
 * control logic leaves stored sample data untouched.
 */
`timescale 1ns/10ps

module mcs_sample_mem #(
   parameter int W = 32,
   parameter int AW = 3
) (
   input wire logic clk_in, // Core clock.
   input wire logic wr_en_in, // Write strobe.
   input wire logic [AW-1:0] wr_addr_in, // Write address.
   input wire logic [W-1:0] wr_data_in, // Write data.
   input wire logic rd_en_in, // Read strobe.
   input wire logic [AW-1:0] rd_addr_in, // Read address.
   output logic [W-1:0] rd_data_out // Read data, one cycle late.
);

   logic [W-1:0] mem_r [0:(1<<AW)-1];

   // Storage and read register; no reset on purpose.
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
      if (rd_en_in) begin
         rd_data_out <= mem_r[rd_addr_in];
      end
   end

endmodule // mcs_sample_mem

/* File: verilog/mcs_stream_port.sv */
/*
 * Streaming sample port and pacing control of a multi-carrier
 * up/down-converter, with packet framing check, event flags and a
 * simple combining and quarter-rate mixing datapath.
 * Assumes source and sink run on clk_in; mode and option inputs are
 * static configuration from the same clock domain.
 */
`timescale 1ns/10ps
`include "mcs_cfg.svh"

module mcs_stream_port #(
   parameter int SAMPLE_W = `MCS_SAMPLE_W,
   parameter int PKT_LEN = `MCS_PKT_LEN,
   parameter int IN_PERIOD = `MCS_IN_PERIOD,
   parameter bit HAS_LAST = 1'b1
) (
   input wire logic clk_in, // Core clock, 20 MHz.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic mode_up_in, // High for up, low for down conversion.
   input wire logic fs4_mix_en_in, // Down mode quarter-rate mixer on.
   input wire logic [2:0] flag_enable_in, // Per-flag enable, level.
   input wire logic [2:0] flag_clear_in, // Per-flag clear, pulse.
   input wire logic input_valid_in, // Source has a sample.
   input wire logic input_last_marker_in, // Last sample of packet.
   input wire logic [SAMPLE_W-1:0] input_sample_bus_in, // Sample word.
   output logic input_ready_out, // Converter takes a sample.
   output logic output_valid_out, // Output sample present.
   input wire logic output_ready_in, // Sink takes the sample.
   output logic [SAMPLE_W-1:0] output_sample_bus_out, // Output word.
   output logic missing_input_flag_out, // Sticky missing input.
   output logic packet_error_flag_out, // Sticky framing error.
   output logic lost_output_flag_out, // Sticky lost output.
   output logic combined_interrupt_out // OR of the flags.
);

   localparam int HALF = SAMPLE_W / 2;
   localparam int PW = (PKT_LEN > 1) ? $clog2(PKT_LEN) : 1;
   localparam int AW = PW + 1;
   localparam int CW = $clog2(IN_PERIOD + 1);
   localparam logic [PW-1:0] POS_LAST = PW'(PKT_LEN - 1);
   localparam logic [CW-1:0] PACE_LAST = CW'(IN_PERIOD - 2);

   mcs_pkg::mcs_in_state_t in_st_r, in_st_nxt;
   logic [CW-1:0] pace_r, pace_nxt;
   logic [PW-1:0] pos_r, pos_nxt;
   logic wbank_r, wbank_nxt;
   logic job_go;
   logic accept;
   logic marker_late;
   logic miss_set, perr_set, lost_set;

   mcs_pkg::mcs_en_state_t en_st_r, en_st_nxt;
   logic [PW-1:0] rd_cnt_r, rd_cnt_nxt;
   logic rbank_r, rbank_nxt;
   logic rd_issue;
   logic dv_r, dv_nxt;
   logic dfirst_r, dfirst_nxt;
   logic dlast_r, dlast_nxt;
   logic [SAMPLE_W-1:0] rd_data;
   logic [HALF-1:0] acc_i_r, acc_i_nxt;
   logic [HALF-1:0] acc_q_r, acc_q_nxt;
   logic [HALF-1:0] sum_i, sum_q;
   logic [1:0] phase_r, phase_nxt;
   logic out_valid_r, out_valid_nxt;
   logic [SAMPLE_W-1:0] out_data_r, out_data_nxt;
   logic drop_r, drop_nxt;
   logic [2:0] flag_r, flag_nxt;

   // Ready is high while waiting for the first sample or in a slot;
   // a missed slot simply stays in the slot state.
   assign input_ready_out = (in_st_r != mcs_pkg::MCS_IN_WAIT);
   assign accept = input_valid_in & input_ready_out;
   // Without HAS_LAST the marker input is ignored and never flags an error.
   assign marker_late = HAS_LAST ? input_last_marker_in : 1'b0;

   // Input pacing and framing. The slot counter restarts on each
   // accepted sample, so a late source shifts the cadence instead of
   // causing a burst of catch-up slots.
   always_comb begin
      in_st_nxt = in_st_r;
      pace_nxt = pace_r;
      pos_nxt = pos_r;
      wbank_nxt = wbank_r;
      job_go = 1'b0;
      miss_set = 1'b0;
      perr_set = 1'b0;
      case (in_st_r)
         mcs_pkg::MCS_IN_FIRST: begin
            if (accept) begin
               in_st_nxt = mcs_pkg::MCS_IN_WAIT;
               pace_nxt = '0;
            end
         end
         mcs_pkg::MCS_IN_WAIT: begin
            if (pace_r >= PACE_LAST) begin
               in_st_nxt = mcs_pkg::MCS_IN_SLOT;
            end else begin
               pace_nxt = pace_r + CW'(1);
            end
         end
         mcs_pkg::MCS_IN_SLOT: begin
            if (accept) begin
               in_st_nxt = mcs_pkg::MCS_IN_WAIT;
               pace_nxt = '0;
            end else begin
               miss_set = 1'b1;
            end
         end
         default: begin
            in_st_nxt = mcs_pkg::MCS_IN_FIRST;
         end
      endcase
      if (accept) begin
         // The own position count decides packet ends; the marker is
         // only compared against it.
         if (HAS_LAST && (marker_late != (pos_r == POS_LAST))) begin
            perr_set = 1'b1;
         end
         if (pos_r == POS_LAST) begin
            pos_nxt = '0;
            wbank_nxt = ~wbank_r;
            job_go = 1'b1;
         end else begin
            pos_nxt = pos_r + PW'(1);
         end
      end
   end

   // Input pacing registers.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         in_st_r <= mcs_pkg::MCS_IN_FIRST;
         pace_r <= '0;
         pos_r <= '0;
         wbank_r <= 1'b0;
      end else begin
         in_st_r <= in_st_nxt;
         pace_r <= pace_nxt;
         pos_r <= pos_nxt;
         wbank_r <= wbank_nxt;
      end
   end

   // Two banks let one packet be read back while the next is stored.
   mcs_sample_mem #(
      .W(SAMPLE_W),
      .AW(AW)
   ) u_mem (
      .clk_in(clk_in),
      .wr_en_in(accept),
      .wr_addr_in({wbank_r, pos_r}),
      .wr_data_in(input_sample_bus_in),
      .rd_en_in(rd_issue),
      .rd_addr_in({rbank_r, rd_cnt_r}),
      .rd_data_out(rd_data)
   );

   assign rd_issue = (en_st_r == mcs_pkg::MCS_EN_READ);
   assign sum_i = (dfirst_r ? '0 : acc_i_r) + rd_data[SAMPLE_W-1:HALF];
   assign sum_q = (dfirst_r ? '0 : acc_q_r) + rd_data[HALF-1:0];

   // Packet engine and output stage. Work starts only when a whole
   // packet has arrived, and samples already stored keep flowing out
   // while the source is late. Sums wrap rather than saturate.
   always_comb begin
      en_st_nxt = en_st_r;
      rd_cnt_nxt = rd_cnt_r;
      rbank_nxt = rbank_r;
      dv_nxt = rd_issue;
      dfirst_nxt = rd_issue && (rd_cnt_r == '0);
      dlast_nxt = rd_issue && (rd_cnt_r == POS_LAST);
      acc_i_nxt = acc_i_r;
      acc_q_nxt = acc_q_r;
      phase_nxt = phase_r;
      out_valid_nxt = 1'b0;
      out_data_nxt = out_data_r;
      drop_nxt = drop_r;
      lost_set = 1'b0;
      case (en_st_r)
         mcs_pkg::MCS_EN_IDLE: begin
            if (job_go) begin
               en_st_nxt = mcs_pkg::MCS_EN_READ;
               rd_cnt_nxt = '0;
               rbank_nxt = wbank_r;
            end
         end
         mcs_pkg::MCS_EN_READ: begin
            if (rd_cnt_r == POS_LAST) begin
               en_st_nxt = mcs_pkg::MCS_EN_IDLE;
            end else begin
               rd_cnt_nxt = rd_cnt_r + PW'(1);
            end
         end
         default: begin
            en_st_nxt = mcs_pkg::MCS_EN_IDLE;
         end
      endcase
      if (dv_r) begin
         acc_i_nxt = sum_i;
         acc_q_nxt = sum_q;
      end
      // A stalled output sample marks the next one for discard; the
      // converter never waits for the sink.
      if (out_valid_r && !output_ready_in) begin
         drop_nxt = 1'b1;
         lost_set = 1'b1;
      end
      if (dv_r && dlast_r) begin
         if (drop_nxt) begin
            drop_nxt = 1'b0;
         end else begin
            out_valid_nxt = 1'b1;
            out_data_nxt = {sum_i, sum_q};
            if (!mode_up_in && fs4_mix_en_in) begin
               // Multiply by exp(-j*pi*n/2): rotate a quarter turn.
               case (phase_r)
                  2'h1: out_data_nxt = {sum_q, -sum_i};
                  2'h2: out_data_nxt = {-sum_i, -sum_q};
                  2'h3: out_data_nxt = {-sum_q, sum_i};
                  default: out_data_nxt = {sum_i, sum_q};
               endcase
               phase_nxt = phase_r + 2'h1;
            end
         end
      end
   end

   // Engine and output registers; the store itself is not reset.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         en_st_r <= mcs_pkg::MCS_EN_IDLE;
         rd_cnt_r <= '0;
         rbank_r <= 1'b0;
         dv_r <= 1'b0;
         dfirst_r <= 1'b0;
         dlast_r <= 1'b0;
         acc_i_r <= '0;
         acc_q_r <= '0;
         phase_r <= `MCS_PHASE_RST;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
         drop_r <= 1'b0;
      end else begin
         en_st_r <= en_st_nxt;
         rd_cnt_r <= rd_cnt_nxt;
         rbank_r <= rbank_nxt;
         dv_r <= dv_nxt;
         dfirst_r <= dfirst_nxt;
         dlast_r <= dlast_nxt;
         acc_i_r <= acc_i_nxt;
         acc_q_r <= acc_q_nxt;
         phase_r <= phase_nxt;
         out_valid_r <= out_valid_nxt;
         out_data_r <= out_data_nxt;
         drop_r <= drop_nxt;
      end
   end

   assign output_valid_out = out_valid_r;
   assign output_sample_bus_out = out_data_r;

   // Sticky flags: a new event beats a clear in the same cycle, and a
   // disabled flag is held low.
   always_comb begin
      flag_nxt = flag_r & ~flag_clear_in;
      flag_nxt[`MCS_FLAG_MISS] = flag_nxt[`MCS_FLAG_MISS] | miss_set;
      flag_nxt[`MCS_FLAG_PERR] = flag_nxt[`MCS_FLAG_PERR] | perr_set;
      flag_nxt[`MCS_FLAG_LOST] = flag_nxt[`MCS_FLAG_LOST] | lost_set;
      flag_nxt = flag_nxt & flag_enable_in;
   end

   // Flag registers.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flag_r <= `MCS_FLAGS_RST;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign missing_input_flag_out = flag_r[`MCS_FLAG_MISS];
   assign packet_error_flag_out = flag_r[`MCS_FLAG_PERR];
   assign lost_output_flag_out = flag_r[`MCS_FLAG_LOST];
   assign combined_interrupt_out = |flag_r;

endmodule // mcs_stream_port

/* File: tb/mcs_stream_port_checker.sv */
/* Port-level timing checks of the converter stream port.
   Assumes it is bound to every instance of mcs_stream_port. */
`timescale 1ns/10ps

module mcs_stream_port_checker #(
   parameter int PKT_LEN = 4,
   parameter int IN_PERIOD = 8
) (
   input wire logic clk_in, // Core clock.
   input wire logic rst_n_in, // Reset, active low.
   input wire logic [2:0] flag_enable_in, // Flag enables.
   input wire logic [2:0] flag_clear_in, // Flag clears.
   input wire logic input_valid_in, // Source valid.
   input wire logic input_last_marker_in, // Packet end.
   input wire logic input_ready_out, // Converter ready.
   input wire logic output_valid_out, // Output present.
   input wire logic output_ready_in, // Sink ready.
   input wire logic missing_input_flag_out, // Miss flag.
   input wire logic packet_error_flag_out, // Framing flag.
   input wire logic lost_output_flag_out, // Lost flag.
   input wire logic combined_interrupt_out // OR of flags.
);
   localparam int LAT = PKT_LEN + 2;
   logic acc, pkt_end;
   logic [2:0] fl, en;
   int gap_r, gap_nxt, pos_r, pos_nxt;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Shorthands shared by several properties.
   assign acc = input_valid_in && input_ready_out;
   assign pkt_end = acc && pos_r == PKT_LEN - 1;
   assign en = flag_enable_in;
   assign fl = {lost_output_flag_out, packet_error_flag_out,
                missing_input_flag_out};

   // Gap 0 means no sample taken since reset, so the first wait is free.
   always_comb begin
      gap_nxt = gap_r;
      pos_nxt = pos_r;
      if (acc) begin
         gap_nxt = 1;
         pos_nxt = pkt_end ? 0 : pos_r + 1;
      end else if (gap_r != 0 && gap_r < IN_PERIOD) begin
         gap_nxt = gap_r + 1;
      end
      if (!rst_n_in) begin
         gap_nxt = 0;
         pos_nxt = 0;
      end
   end

   // Registers of the helper counters.
   always_ff @(posedge clk_in) begin
      gap_r <= gap_nxt;
      pos_r <= pos_nxt;
   end

   first_ready_a: assert property (gap_r == 0 |-> input_ready_out)
      else $error("ready low before first sample");
   gap_low_a: assert property (gap_r > 0 && gap_r < IN_PERIOD
      |-> !input_ready_out) else $error("ready high inside period");
   slot_high_a: assert property (gap_r == IN_PERIOD
      |-> input_ready_out) else $error("ready dropped in open slot");
   miss_set_a: assert property (input_ready_out && !input_valid_in
      && gap_r != 0 && en[0] |=> missing_input_flag_out)
      else $error("missing input not flagged");
   perr_set_a: assert property (en[1] && acc
      && input_last_marker_in != (pos_r == PKT_LEN - 1)
      |=> packet_error_flag_out) else $error("no packet error");
   lost_set_a: assert property (en[2] && output_valid_out
      && !output_ready_in |=> lost_output_flag_out)
      else $error("lost output not flagged");
   flag_stick_a: assert property (1 |=> ($past(fl)
      & ~$past(flag_clear_in) & $past(en) & ~fl) == 3'h0)
      else $error("flag fell without clear");
   flag_off_a: assert property ((fl & $past(en)) == fl)
      else $error("disabled flag high");
   or_flags_a: assert property (combined_interrupt_out == |fl)
      else $error("combined interrupt wrong");
   out_pulse_a: assert property (output_valid_out
      |=> !output_valid_out) else $error("output valid too long");
   out_cause_a: assert property (output_valid_out
      |-> $past(pkt_end, LAT)) else $error("output without packet");

   cover property (pkt_end);
   cover property (output_valid_out && output_ready_in);
   cover property (output_valid_out && !output_ready_in);
   cover property (input_ready_out && !input_valid_in && gap_r != 0);
endmodule // mcs_stream_port_checker

bind mcs_stream_port mcs_stream_port_checker #(
   .PKT_LEN(PKT_LEN),
   .IN_PERIOD(IN_PERIOD)
) chk_u (
   .clk_in, .rst_n_in, .flag_enable_in, .flag_clear_in,
   .input_valid_in, .input_last_marker_in, .input_ready_out,
   .output_valid_out, .output_ready_in, .missing_input_flag_out,
   .packet_error_flag_out, .lost_output_flag_out, .combined_interrupt_out
);

/* File: tb/mcs_sink_model.sv */
/* Downstream sink model of the converter output stream.
   Assumes the converter's core clock. */
`timescale 1ns/10ps

module mcs_sink_model (
   input wire logic clk_in, // Core clock.
   input wire logic stall_in, // Bench asks the sink to hold off.
   input wire logic output_valid_in, // Converter output valid.
   input wire logic [31:0] output_sample_bus_in, // Converter word.
   output logic output_ready_out, // Sink ready.
   output int taken_out, // Words taken so far.
   output logic [31:0] word_out // Last word taken.
);
   // A real sink ties ready high; stalling exists only to provoke loss.
   assign output_ready_out = !stall_in;

   // Words count only where valid and ready meet at an edge; one
   // process owns both outputs so each has a single driver.
   initial begin
      taken_out = 0;
      word_out = 32'h0;
      forever begin
         @(posedge clk_in);
         if (output_valid_in && output_ready_out) begin
            taken_out <= taken_out + 1;
            word_out <= output_sample_bus_in;
         end
      end
   end
endmodule // mcs_sink_model

/* File: tb/mcs_stream_port_tb_top.sv */
/* Self-checking testbench of the converter stream port.
   Assumes the checker binds itself and the sink model is compiled. */
`timescale 1ns/10ps

module mcs_stream_port_tb_top;
   localparam int PKT = 4;
   logic clk_in, rst_n_in, mode_up_in, fs4_mix_en_in, stall;
   logic input_valid_in, input_last_marker_in, output_ready_in;
   logic [2:0] flag_enable_in, flag_clear_in;
   logic [31:0] input_sample_bus_in, output_sample_bus_out;
   logic input_ready_out, output_valid_out, missing_input_flag_out;
   logic packet_error_flag_out, lost_output_flag_out;
   logic combined_interrupt_out;
   logic [15:0] si, sq;
   logic [31:0] sink_word;
   int miscompares = 0;
   int n_checks = 0;
   int taken;

   mcs_stream_port #(.PKT_LEN(PKT)) dut_u (.clk_in, .rst_n_in,
      .mode_up_in, .fs4_mix_en_in, .flag_enable_in, .flag_clear_in,
      .input_valid_in, .input_last_marker_in, .input_sample_bus_in,
      .input_ready_out, .output_valid_out, .output_ready_in,
      .output_sample_bus_out, .missing_input_flag_out,
      .packet_error_flag_out, .lost_output_flag_out,
      .combined_interrupt_out);
   mcs_sink_model sink_u (.clk_in, .stall_in(stall),
      .output_valid_in(output_valid_out),
      .output_sample_bus_in(output_sample_bus_out),
      .output_ready_out(output_ready_in), .taken_out(taken),
      .word_out(sink_word));

   // Clock of 50 ns.
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic do_reset();
      rst_n_in = 1'b0;
      tick(8);
      rst_n_in = 1'b1;
   endtask

   // Holds the word until ready is seen; valid stays up between words
   // of a packet, which the converter ignores while ready is low.
   task automatic send(logic lst, logic [31:0] d);
      int n = 0;
      input_valid_in = 1'b1;
      input_last_marker_in = lst;
      input_sample_bus_in = d;
      while (input_ready_out !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk("ready slot", 1, input_ready_out);
      tick(1);
   endtask

   // Sends words base+i from position from; bad adds a stray marker.
   task automatic pkt(logic [31:0] base, int bad, int from);
      logic [31:0] d;
      si = 16'h0;
      sq = 16'h0;
      for (int i = from; i < PKT; i++) begin
         d = base + i;
         si += d[31:16];
         sq += d[15:0];
         send((i == PKT - 1) != (i == bad), d);
      end
      // Release after the packet and scramble the stale bus.
      input_valid_in = 1'b0;
      input_sample_bus_in = ~d;
   endtask

   task automatic out_chk(logic [31:0] e);
      int n = 0;
      while (output_valid_out !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("latency", PKT + 1, n);
      chk("output word", e, output_sample_bus_out);
   endtask

   task automatic t_idle();
      repeat (12) begin
         chk("ready idle", 1, input_ready_out);
         tick(1);
      end
      chk("flags", 0, {combined_interrupt_out, output_valid_out});
      chk("output bus", 0, output_sample_bus_out);
   endtask

   task automatic t_up();
      int c = taken;
      pkt(32'h00010002, -1, 0);
      chk("miss", 0, missing_input_flag_out);
      out_chk({si, sq});
      tick(1);
      chk("taken", c + 1, taken);
      chk("sink word", {si, sq}, sink_word);
   endtask

   task automatic t_miss();
      flag_enable_in = 3'h6;
      tick(12);
      chk("ready held", 1, input_ready_out);
      chk("miss off", 0, missing_input_flag_out);
      flag_enable_in = 3'h7;
      tick(2);
      chk("miss", 1, missing_input_flag_out);
      chk("combined", 1, combined_interrupt_out);
      flag_clear_in = 3'h1;
      input_valid_in = 1'b1;
      input_last_marker_in = 1'b0;
      input_sample_bus_in = 32'h00200000;
      tick(1);
      flag_clear_in = 3'h0;
      chk("miss cleared", 0, missing_input_flag_out);
      pkt(32'h00200000, -1, 1);
      out_chk({si + 16'h0020, sq});
   endtask

   task automatic t_perr();
      pkt(32'h00100001, 1, 0);
      chk("perr", 1, packet_error_flag_out);
      out_chk({si, sq});
      flag_clear_in = 3'h2;
      tick(1);
      flag_clear_in = 3'h0;
      chk("perr cleared", 0, packet_error_flag_out);
   endtask

   task automatic t_lost();
      int c = taken;
      stall = 1'b1;
      pkt(32'h00300001, -1, 0);
      out_chk({si, sq});
      tick(1);
      stall = 1'b0;
      chk("lost", 1, lost_output_flag_out);
      pkt(32'h00400001, -1, 0);
      repeat (PKT + 3) begin
         chk("dropped", 0, output_valid_out);
         tick(1);
      end
      pkt(32'h00500001, -1, 0);
      out_chk({si, sq});
      tick(1);
      chk("taken", c + 1, taken);
   endtask

   task automatic t_down();
      mode_up_in = 1'b0;
      fs4_mix_en_in = 1'b1;
      do_reset();
      t_idle();
      pkt(32'h00050003, -1, 0);
      out_chk({si, sq});
      pkt(32'h00070001, -1, 0);
      out_chk({sq, 16'h0 - si});
   endtask

   task automatic results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence; all inputs get a value at time zero.
   initial begin
      mode_up_in = 1'b1;
      fs4_mix_en_in = 1'b0;
      stall = 1'b0;
      flag_enable_in = 3'h7;
      flag_clear_in = 3'h0;
      input_valid_in = 1'b0;
      input_last_marker_in = 1'b0;
      input_sample_bus_in = 32'h0;
      do_reset();
      t_idle();
      t_up();
      t_miss();
      t_perr();
      t_lost();
      t_down();
      results();
   end

   // The run needs well under a thousand cycles; this cuts a hang.
   initial begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      results();
   end
endmodule // mcs_stream_port_tb_top
